// ---- usrsc_buf2.v ----
// Two-entry buffer holding received characters between framer and host output register.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module usrsc_buf2 (
    // Clock and reset.
    input wire sys_clk,
    input wire rst,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [8:0] in_data,
    // Draining side.
    output wire out_valid,
    input wire out_ready,
    output reg [8:0] out_data
);
    reg [8:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @*
    begin
        out_data = mem_q[rd_q];
    end
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 2'h1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // usrsc_buf2

// ---- usrsc_line_model.sv ----
// Model of the far end of the serial line: a clock and data bits, LSB first.
// Assumes the bench calls send and that the block takes bits on falling clock edges.
`timescale 1ns/1ps
module usrsc_line_model (
    // Line to the receiver.
    output logic rx_clk,
    output logic rx_serial_in
);
    initial
    begin
        rx_clk = 1'b1;
        rx_serial_in = 1'b0;
    end
    // The clock stands high between frames, and the data is flipped so no stale bit lingers.
    task automatic send(input logic [8:0] v, input int n);
        #10;
        for (int k = 0; k < n; k++)
        begin
            rx_serial_in = v[k];
            #400 rx_clk = 1'b0;
            #400 rx_clk = 1'b1;
        end
        rx_serial_in = ~rx_serial_in;
    endtask
endmodule // usrsc_line_model

// ---- usrsc_regs.vh ----
// Constants for the synchronous receiver status and control block.
// Assumes inclusion by bare name from the design files.
`ifndef USRSC_REGS_VH
`define USRSC_REGS_VH
`define USRSC_STAT_AVAIL_BIT 0
`define USRSC_STAT_OVR_BIT 1
`define USRSC_STAT_PERR_BIT 2
`define USRSC_STAT_SYNC_BIT 3
`define USRSC_STAT_FILL_BIT 6
`define USRSC_STAT_TXE_BIT 7
`define USRSC_CTRL_RESET 4'hf
`define USRSC_LEN_BASE 4'h5
`define USRSC_BUF_DEPTH 2
`endif

// ---- usrsc_rx.v ----
// Receiver status, sync hunt and character format control of a synchronous serial receiver.
// Assumes host strobes and serial pins are asynchronous and are synchronised here on sys_clk.
// Notes on behaviour
// - While status view strobe is low and data view strobe is high, status word drives the received-data outputs.
// - Status strobe rising edge clears fill-sent, overrun, parity-error and sync-match flags.
// - Overrun sets when a character moves to output while character-available is high.
// - Overrun clears on status strobe end, low restart, or master reset.
// - Status word shows overrun on output bit 1.
// - Parity error sets when transferred character parity disagrees with selected sense.
// - Parity error clears on good next character, status strobe end, restart, reset.
// - Status word shows parity error on output bit 2.
// - While restart is low, overrun and parity error are held low.
// - Restart rising edge enters hunt mode, comparing shift register each bit time.
// - Hunt compares selected length; match sets sync flag, copies sync to output.
// - After first match, frame one character every character time.
// - First sync character found in hunt is not parity checked.
// - Length inputs select 5, 6, 7 or 8 data bits, parity not counted.
// - Unused high data outputs read low; data right justified from bit 0.
// - Parity disable removes parity generation and checking.
// - Parity sense high selects even parity, low selects odd.
// - Low configuration load strobe captures length and parity controls.
// - Master reset clears parity error, sync match and character available.
// - After master reset, sync compare stays off until a restart pulse.
// - Outside idle, sync flag sets at a falling receive clock when shift register equals sync register.
`timescale 1ns/1ps
module usrsc_rx (
    // Clock and reset.
    input wire sys_clk,
    input wire rst,
    // Serial receive line.
    input wire rx_clk,
    input wire rx_serial_in,
    // Host strobes, all active low.
    input wire status_view_n,
    input wire data_view_n,
    input wire config_load_n,
    input wire sync_load_n,
    input wire receiver_hunt_restart_n,
    // Format control and sync character inputs.
    input wire char_length_sel0,
    input wire char_length_sel1,
    input wire parity_disable,
    input wire parity_even_select,
    input wire [7:0] host_in,
    // Transmitter flags shown in the status word.
    input wire fill_event,
    input wire tx_empty,
    // Outputs.
    output reg [7:0] rx_out_bus,
    output reg rx_out_oe_n,
    output wire overrun_flag,
    output wire parity_error_flag,
    output wire sync_match_flag,
    output wire fill_sent_flag,
    output wire char_available_flag
);
    `include "usrsc_regs.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_HUNT = 2'h1;
    localparam ST_WORD = 2'h2;
    localparam IN_N = 20;
    // Every pin input except tx_empty passes two flip-flops before use.
    wire [IN_N-1:0] pin_raw;
    reg [IN_N-1:0] pin_s1_q;
    reg [IN_N-1:0] pin_s2_q;
    reg [IN_N-1:0] pin_prev_q;
    // Control and sync data ride beside their strobes, so both arrive equally late.
    assign pin_raw = {host_in, parity_even_select, parity_disable, char_length_sel1,
        char_length_sel0, rx_clk, rx_serial_in, status_view_n, data_view_n, config_load_n,
        sync_load_n, receiver_hunt_restart_n, fill_event};
    genvar gi;
    generate
        for (gi = 0; gi < IN_N; gi = gi + 1)
        begin : g_sync
            always @(posedge sys_clk)
            begin
                if (rst)
                begin
                    pin_s1_q[gi] <= 1'b1;
                    pin_s2_q[gi] <= 1'b1;
                    pin_prev_q[gi] <= 1'b1;
                end
                else
                begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_prev_q[gi] <= pin_s2_q[gi];
                end
            end
        end
    endgenerate
    wire rclk_fall = pin_prev_q[7] && !pin_s2_q[7];
    wire rx_bit = pin_s2_q[6];
    wire stat_lo = !pin_s2_q[5];
    wire stat_end = !pin_prev_q[5] && pin_s2_q[5];
    wire data_lo = !pin_s2_q[4];
    wire data_end = !pin_prev_q[4] && pin_s2_q[4];
    wire cfg_lo = !pin_s2_q[3];
    wire sync_lo = !pin_s2_q[2];
    wire rr_lo = !pin_s2_q[1];
    wire rr_end = !pin_prev_q[1] && pin_s2_q[1];
    wire fill_rise = !pin_prev_q[0] && pin_s2_q[0];
    // Control register and sync register.
    reg [3:0] ctrl_q;
    reg [7:0] sync_char_q;
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= `USRSC_CTRL_RESET;
            sync_char_q <= 8'h00;
        end
        else
        begin
            if (cfg_lo)
                ctrl_q <= pin_s2_q[11:8];
            if (sync_lo)
                sync_char_q <= pin_s2_q[19:12];
        end
    end
    wire [3:0] len = `USRSC_LEN_BASE + {2'h0, ctrl_q[1:0]};
    wire par_off = ctrl_q[2];
    wire par_even = ctrl_q[3];
    reg [7:0] len_mask;
    always @*
    begin
        case (ctrl_q[1:0])
            2'h0: len_mask = 8'h1f;
            2'h1: len_mask = 8'h3f;
            2'h2: len_mask = 8'h7f;
            default: len_mask = 8'hff;
        endcase
    end
    // Shift register: newest bit enters at the top of the selected length.
    reg [7:0] shift_q;
    reg [1:0] state_q;
    reg [3:0] bit_cnt_q;
    reg par_phase_q;
    reg par_acc_q;
    reg skip_par_q;
    reg [7:0] shift_next;
    always @*
    begin
        shift_next = ((shift_q >> 1) | ({7'h00, rx_bit} << (len - 4'h1))) & len_mask;
    end
    wire hunt_hit = (state_q == ST_HUNT) && rclk_fall && (shift_next == (sync_char_q & len_mask));
    reg push_q;
    reg [8:0] push_data_q;
    wire buf_in_ready;
    always @(posedge sys_clk)
    begin
        push_q <= push_q && !buf_in_ready;
        if (rst)
        begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            par_phase_q <= 1'b0;
            par_acc_q <= 1'b0;
            skip_par_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 9'h000;
        end
        else if (rr_lo)
        begin
            // Old bits must not combine with new ones into a false sync match.
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            skip_par_q <= 1'b0;
            push_q <= 1'b0;
        end
        else if (rr_end)
        begin
            state_q <= ST_HUNT;
        end
        else if (rclk_fall && state_q != ST_IDLE)
        begin
            if (state_q == ST_HUNT)
            begin
                shift_q <= shift_next;
                if (hunt_hit)
                begin
                    // Sync copy goes out with parity check suppressed.
                    push_q <= 1'b1;
                    push_data_q <= {1'b1, shift_next};
                    state_q <= ST_WORD;
                    bit_cnt_q <= 4'h0;
                    par_phase_q <= 1'b0;
                    skip_par_q <= !par_off;
                    par_acc_q <= 1'b0;
                end
            end
            else if (skip_par_q)
            begin
                skip_par_q <= 1'b0;
            end
            else if (par_phase_q)
            begin
                par_phase_q <= 1'b0;
                push_q <= 1'b1;
                // Even parity is good when data and parity bit hold an even count of ones.
                push_data_q <= {(par_acc_q ^ rx_bit) != par_even, shift_q};
            end
            else
            begin
                shift_q <= shift_next;
                par_acc_q <= (bit_cnt_q == 4'h0) ? rx_bit : (par_acc_q ^ rx_bit);
                if (bit_cnt_q == len - 4'h1)
                begin
                    bit_cnt_q <= 4'h0;
                    if (par_off)
                    begin
                        push_q <= 1'b1;
                        push_data_q <= {1'b1, shift_next};
                    end
                    else
                        par_phase_q <= 1'b1;
                end
                else
                    bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end
    // A pending character is held until the buffer has room, so a stall loses no word.
    wire buf_valid;
    wire [8:0] buf_data;
    usrsc_buf2 u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(push_q && !rr_lo),
        .in_ready(buf_in_ready),
        .in_data(push_data_q),
        .out_valid(buf_valid),
        .out_ready(1'b1),
        .out_data(buf_data)
    );
    // Output register and flags.
    reg [7:0] out_reg_q;
    reg avail_q;
    reg ovr_q;
    reg perr_q;
    reg sync_q;
    reg fill_q;
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            out_reg_q <= 8'h00;
            avail_q <= 1'b0;
            ovr_q <= 1'b0;
            perr_q <= 1'b0;
            sync_q <= 1'b0;
            fill_q <= 1'b0;
        end
        else
        begin
            if (buf_valid)
                out_reg_q <= buf_data[7:0] & len_mask;
            // Set wins over clear for every flag except overrun and parity error, which low restart clears first; flags otherwise hold.
            if (buf_valid)
                avail_q <= 1'b1;
            else if (data_end || rr_lo)
                avail_q <= 1'b0;
            if (rr_lo)
                ovr_q <= 1'b0;
            else if (buf_valid && avail_q)
                ovr_q <= 1'b1;
            else if (stat_end)
                ovr_q <= 1'b0;
            if (rr_lo)
                perr_q <= 1'b0;
            else if (buf_valid)
                perr_q <= !buf_data[8];
            else if (stat_end)
                perr_q <= 1'b0;
            if (hunt_hit || (state_q != ST_IDLE && shift_q == (sync_char_q & len_mask)
                && rclk_fall))
                sync_q <= 1'b1;
            else if (stat_end || rr_lo)
                sync_q <= 1'b0;
            if (fill_rise)
                fill_q <= 1'b1;
            else if (stat_end)
                fill_q <= 1'b0;
        end
    end
    assign overrun_flag = ovr_q;
    assign parity_error_flag = perr_q;
    assign sync_match_flag = sync_q;
    assign fill_sent_flag = fill_q;
    assign char_available_flag = avail_q;
    reg [7:0] stat_word;
    always @*
    begin
        stat_word = 8'h00;
        stat_word[`USRSC_STAT_AVAIL_BIT] = avail_q;
        stat_word[`USRSC_STAT_OVR_BIT] = ovr_q;
        stat_word[`USRSC_STAT_PERR_BIT] = perr_q;
        stat_word[`USRSC_STAT_SYNC_BIT] = sync_q;
        stat_word[`USRSC_STAT_FILL_BIT] = fill_q;
        stat_word[`USRSC_STAT_TXE_BIT] = tx_empty;
    end
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            rx_out_bus <= 8'h00;
            rx_out_oe_n <= 1'b1;
        end
        else if (stat_lo && !data_lo)
        begin
            rx_out_bus <= stat_word;
            rx_out_oe_n <= 1'b0;
        end
        else if (data_lo && !stat_lo)
        begin
            rx_out_bus <= out_reg_q;
            rx_out_oe_n <= 1'b0;
        end
        else
        begin
            rx_out_bus <= 8'h00;
            rx_out_oe_n <= 1'b1;
        end
    end
endmodule // usrsc_rx

// ---- usrsc_rx_monitor.sv ----
// Checker for the receiver status block, watching only the top module's ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module usrsc_rx_monitor (
    // Clock and reset.
    input logic sys_clk,
    input logic rst,
    // Host side.
    input logic status_view_n,
    input logic data_view_n,
    input logic receiver_hunt_restart_n,
    input logic parity_disable,
    // Outputs watched.
    input logic [7:0] rx_out_bus,
    input logic rx_out_oe_n,
    input logic overrun_flag,
    input logic parity_error_flag,
    input logic sync_match_flag,
    input logic fill_sent_flag,
    input logic char_available_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0] clr_age_q;
    logic armed_q;
    // Clears trail the pins through two synchronisers, so a short age is allowed.
    always @(posedge sys_clk)
    begin
        if (rst || !status_view_n || !receiver_hunt_restart_n)
            clr_age_q <= 4'h0;
        else if (clr_age_q != 4'hf)
            clr_age_q <= clr_age_q + 4'h1;
        armed_q <= !rst && (armed_q || !receiver_hunt_restart_n);
    end
    sequence stat_on;
        (!status_view_n && data_view_n)[*5];
    endsequence
    sequence view_end;
        !status_view_n[*4] ##1 status_view_n;
    endsequence
    status_drive_a: assert property (stat_on |-> !rx_out_oe_n)
        else $error("status word not driven");
    ovr_bit_a: assert property (stat_on ##0 $stable(overrun_flag) |->
        rx_out_bus[1] == overrun_flag) else $error("overrun bit wrong");
    perr_bit_a: assert property (stat_on ##0 $stable(parity_error_flag) |->
        rx_out_bus[2] == parity_error_flag) else $error("parity bit wrong");
    view_clear_a: assert property (view_end |-> ##[1:5]
        !(overrun_flag || parity_error_flag || sync_match_flag || fill_sent_flag))
        else $error("flags not cleared");
    ovr_cause_a: assert property ($rose(overrun_flag) |-> $past(char_available_flag))
        else $error("overrun without pending char");
    flag_latch_a: assert property ($fell(overrun_flag) || $fell(sync_match_flag) ||
        $fell(fill_sent_flag) |-> clr_age_q < 4'h8) else $error("flag dropped alone");
    hunt_off_a: assert property (!armed_q |-> !sync_match_flag)
        else $error("sync found before restart");
    restart_hold_a: assert property (!receiver_hunt_restart_n[*5] |->
        !overrun_flag && !parity_error_flag) else $error("flags set in restart");
    perr_off_a: assert property ($rose(parity_error_flag) |-> !parity_disable)
        else $error("parity checked while disabled");
endmodule // usrsc_rx_monitor
bind usrsc_rx usrsc_rx_monitor u_mon (.sys_clk, .rst, .status_view_n, .data_view_n,
    .receiver_hunt_restart_n, .parity_disable, .rx_out_bus, .rx_out_oe_n, .overrun_flag,
    .parity_error_flag, .sync_match_flag, .fill_sent_flag, .char_available_flag);

// ---- usrsc_rx_test.sv ----
// Self-checking bench for the receiver status block with a serial line model.
// Assumes a 100 ns clock and a synchronous active-high reset.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module usrsc_rx_test;
    logic sys_clk, rst, rx_clk, rx_serial_in, status_view_n, data_view_n;
    logic config_load_n, sync_load_n, receiver_hunt_restart_n, char_length_sel0;
    logic char_length_sel1, parity_disable, parity_even_select, fill_event, tx_empty;
    logic rx_out_oe_n, overrun_flag, parity_error_flag, sync_match_flag;
    logic fill_sent_flag, char_available_flag, was_on;
    logic [7:0] host_in, rx_out_bus, sy, c1, c2, mask, ev;
    logic [7:0] exp_q[$];
    int err_count, total_checks, len;
    logic [4:0] flags;
    usrsc_rx DUT (.sys_clk, .rst, .rx_clk, .rx_serial_in, .status_view_n, .data_view_n,
        .config_load_n, .sync_load_n, .receiver_hunt_restart_n, .char_length_sel0,
        .char_length_sel1, .parity_disable, .parity_even_select, .host_in, .fill_event,
        .tx_empty, .rx_out_bus, .rx_out_oe_n, .overrun_flag, .parity_error_flag,
        .sync_match_flag, .fill_sent_flag, .char_available_flag);
    usrsc_line_model line (.rx_clk, .rx_serial_in);
    assign flags = {overrun_flag, parity_error_flag, sync_match_flag, fill_sent_flag,
        char_available_flag};
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // A view strobe notes what the bus should show, then holds it past the output latency.
    task automatic view(input logic st, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        if (st)
            status_view_n <= 1'b0;
        else
            data_view_n <= 1'b0;
        tick(6);
        status_view_n <= 1'b1;
        data_view_n <= 1'b1;
        tick(6);
    endtask
    function automatic logic [8:0] frame(input logic [7:0] d, input logic bad);
        logic p;
        p = ^d ^ !parity_even_select ^ bad;
        frame = {1'b0, d} | ({8'h00, p} << len);
    endfunction
    always @(negedge sys_clk)
    begin
        if (rx_out_oe_n === 1'b0 && !was_on && exp_q.size() > 0)
        begin
            ev = exp_q.pop_front();
            `CHK("rx_out_bus", ev, rx_out_bus)
        end
        was_on = (rx_out_oe_n === 1'b0);
    end
    initial
    begin
        tick(30000);
        err_count++;
        print_verdict();
    end
    initial
    begin
        rst = 1'b1; status_view_n = 1'b1; data_view_n = 1'b1; config_load_n = 1'b1;
        sync_load_n = 1'b1; receiver_hunt_restart_n = 1'b1; char_length_sel0 = 1'b0;
        char_length_sel1 = 1'b0; parity_disable = 1'b0; parity_even_select = 1'b1;
        fill_event = 1'b0; tx_empty = 1'b0; host_in = 8'h00; was_on = 1'b0;
        err_count = 0; total_checks = 0;
        void'($urandom(32'had74));
        tick(3);
        rst <= 1'b0;
        tick(4);
        `CHK("flags", 5'h00, flags)
        // Sync and shift registers both hold zero here, so a live compare would match.
        line.send(9'h000, 8);
        tick(6);
        `CHK("idle hunt", 1'b0, sync_match_flag)
        for (int i = 0; i < 4; i++)
        begin
            len = 5 + i;
            mask = 8'hff >> (3 - i);
            sy = 8'h96 & mask;
            @(posedge sys_clk);
            {char_length_sel1, char_length_sel0} <= i[1:0];
            parity_disable <= (i == 1);
            parity_even_select <= 1'($urandom);
            tx_empty <= 1'($urandom);
            host_in <= sy;
            config_load_n <= 1'b0;
            sync_load_n <= 1'b0;
            tick(5);
            config_load_n <= 1'b1;
            sync_load_n <= 1'b1;
            tick(4);
            receiver_hunt_restart_n <= 1'b0;
            tick(6);
            `CHK("restart", 2'b00, {overrun_flag, parity_error_flag})
            receiver_hunt_restart_n <= 1'b1;
            fill_event <= 1'b1;
            tick(4);
            fill_event <= 1'b0;
            line.send(frame(sy, 1'b0), len + !parity_disable);
            tick(6);
            `CHK("hunt", 3'b101, {sync_match_flag, parity_error_flag, char_available_flag})
            c1 = 8'($urandom) & mask;
            c2 = 8'($urandom) & mask;
            line.send(frame(c1, 1'b1), len + !parity_disable);
            tick(6);
            `CHK("bad char", {1'b1, !parity_disable}, flags[4:3])
            line.send(frame(c2, 1'b0), len + !parity_disable);
            tick(6);
            `CHK("good char", 1'b0, parity_error_flag)
            view(1'b1, {tx_empty, 7'h4b});
            `CHK("cleared", 4'h0, flags[4:1])
            view(1'b0, c2);
            `CHK("avail", 1'b0, char_available_flag)
            line.send(frame(c1, 1'b1), len + !parity_disable);
            tick(6);
        end
        `CHK("pre reset", 2'b11, {parity_error_flag, char_available_flag})
        @(posedge sys_clk);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(2);
        `CHK("mid reset", 5'h00, flags)
        print_verdict();
    end
endmodule // usrsc_rx_test
